// File: inc/psio_pkg.sv
// package: register map, error codes and timing constants of the plc supervisor
// How it works
// R1 - disabled input image ignores its pin
// R2 - disabled output drives only forced value
// R3 - re-enabled points follow pins and scan again
// R4 - stopped: run led 2 s on, 2 s off
// R5 - running: run led 0.25 s on/off
// R6 - run/stop only by tool, state retained
// R7 - program pack: run at power-up if syntax ok
// R8 - runtime fault forces stop, lights error led
// R9 - minor fault waits power cycle, serious waits clear
// R10 - error led dark without system error
// R11 - anomaly: error led flashes, outputs 0-3 show code
// R12 - binary code, output 0 is lsb
// R13 - port is slave: reply only after request
// R14 - rx/tx leds lit while activity lasts
// R15 - input led follows external input
// R16 - output led lit when output driven on
// R17 - blink counters from clock, cleared by reset
package psio_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_IN_DIS    = 8'h04;
	localparam logic [7:0] OFS_IN_FORCE  = 8'h08;
	localparam logic [7:0] OFS_OUT_DIS   = 8'h0C;
	localparam logic [7:0] OFS_OUT_FORCE = 8'h10;
	localparam logic [7:0] OFS_IN_IMAGE  = 8'h14;
	localparam logic [7:0] OFS_OUT_STATE = 8'h18;
	localparam logic [7:0] OFS_ERR_CODE  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;
	////////////////////////////////////////////////////////////////////////////////
	// control register fields (write: commands, read: state)
	localparam int CTRL_START       = 0;
	localparam int CTRL_STOP        = 1;
	localparam int CTRL_CLEAR_FAULT = 2;
	localparam int STAT_RUN         = 0;
	localparam int STAT_ERR         = 1;
	localparam int STAT_SERIOUS     = 2;
	localparam int STAT_MINOR       = 3;
	// interrupt status bits
	localparam int IRQ_FAULT   = 0;
	localparam int IRQ_SERIOUS = 1;
	localparam int IRQ_RUNCHG  = 2;
	localparam int IRQ_REQUEST = 3;
	localparam int IRQ_BITS    = 4;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 4'h0;
	////////////////////////////////////////////////////////////////////////////////
	// error codes shown on output leds 0-3
	localparam logic [3:0] ERR_NONE        = 4'h0;
	localparam logic [3:0] ERR_UNSUPPORTED = 4'h1;
	localparam logic [3:0] ERR_ID_MISMATCH = 4'h2;
	localparam logic [3:0] ERR_CHECKSUM    = 4'h3;
	localparam logic [3:0] ERR_STACK       = 4'h4;
	localparam logic [3:0] ERR_WATCHDOG    = 4'h5;
	localparam logic [3:0] ERR_MAIN_IO     = 4'h6;
	localparam logic [3:0] ERR_SYNTAX      = 4'h7;
	localparam logic [3:0] ERR_EXP_MODULES = 4'h8;
	localparam logic [3:0] ERR_EXP_POINTS  = 4'h9;
	localparam logic [3:0] ERR_FLASH_CRC   = 4'hA;
	localparam logic [3:0] ERR_RESERVED_B  = 4'hB;
	localparam logic [3:0] ERR_RESERVED_F  = 4'hF;
	////////////////////////////////////////////////////////////////////////////////
	// timing: clock rate and indicator half periods
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned STOP_HALF_MS    = 2000;
	localparam int unsigned RUN_HALF_MS     = 250;
	localparam int unsigned FLASH_HALF_MS   = 500;
	localparam int unsigned STOP_HALF_CYC   = CLK_HZ / 1000 * STOP_HALF_MS;
	localparam int unsigned RUN_HALF_CYC    = CLK_HZ / 1000 * RUN_HALF_MS;
	localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int          BLINK_W         = 26;
endpackage : psio_pkg

// File: core/psio_blink.sv
// module: indicator blinker with a run-time half period
`timescale 1ns/1ps
module psio_blink #(
	parameter int W = 26
) (
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic         i_enable,
	input  wire logic [W-1:0] i_half,
	output logic              o_led
);
	logic [W-1:0] count;

	// half-period counter, led starts on when enabled
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_enable) begin // R17
			count <= '0;
			o_led <= 1'b0;
		end else if (count == '0 && !o_led) begin
			o_led <= 1'b1;
			count <= W'(1);
		end else if (count >= i_half) begin
			o_led <= ~o_led;
			count <= W'(1);
		end else begin
			count <= count + W'(1);
		end
	end
endmodule : psio_blink

// File: core/psio_top.sv
// module: plc supervision, indicators and i/o disable/force over wishbone
`timescale 1ns/1ps
module psio_top #(
	parameter int              N_IN       = 8,
	parameter int              N_OUT      = 8,
	parameter int unsigned     STOP_HALF  = psio_pkg::STOP_HALF_CYC,
	parameter int unsigned     RUN_HALF   = psio_pkg::RUN_HALF_CYC,
	parameter int unsigned     FLASH_HALF = psio_pkg::FLASH_HALF_CYC
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// wishbone slave
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [7:0]       i_wb_adr,
	input  wire logic [3:0]       i_wb_sel,
	input  wire logic [31:0]      i_wb_dat,
	output logic      [31:0]      o_wb_dat,
	output logic                  o_wb_ack,
	output logic                  o_irq,
	// i/o points
	input  wire logic [N_IN-1:0]  i_input_point,
	output logic      [N_IN-1:0]  o_input_image,
	output logic      [N_IN-1:0]  o_input_led,
	input  wire logic [N_OUT-1:0] i_scan_out,
	output logic      [N_OUT-1:0] o_output_point,
	output logic      [N_OUT-1:0] o_output_led,
	// run state, retention and program pack
	input  wire logic             i_retained_run,
	input  wire logic             i_pack_present,
	input  wire logic             i_pack_syntax_ok,
	output logic                  o_retain_run,
	output logic                  o_scan_enable,
	// runtime faults
	input  wire logic             i_fault,
	input  wire logic             i_fault_serious,
	input  wire logic [3:0]       i_fault_code,
	// built-in port activity
	input  wire logic             i_rx_busy,
	input  wire logic             i_tx_busy,
	output logic                  o_tx_grant,
	output logic                  o_rx_led,
	output logic                  o_tx_led,
	// status indicators
	output logic                  o_power_indicator,
	output logic                  o_run_led,
	output logic                  o_err_led
);
	localparam int W = psio_pkg::BLINK_W;

	logic [N_IN-1:0]  in_dis;
	logic [N_IN-1:0]  in_force;
	logic [N_IN-1:0]  in_filt;
	logic [N_OUT-1:0] out_dis;
	logic [N_OUT-1:0] out_force;
	logic [N_OUT-1:0] next_out;
	logic [psio_pkg::IRQ_BITS-1:0] irq_stat;
	logic [psio_pkg::IRQ_BITS-1:0] irq_mask;
	logic [psio_pkg::IRQ_BITS-1:0] irq_set;
	logic [3:0]       err_code;
	logic             run;
	logic             booting;
	logic             err_minor;
	logic             err_serious;
	logic             err_active;
	logic             anomaly;
	logic             req_pending;
	logic             rx_q;
	logic             tx_q;
	logic             wr;
	logic             rd_ok;
	logic [31:0]      rd_data;
	logic             start_cmd;
	logic             stop_cmd;
	logic             clear_cmd;
	logic             run_blink;
	logic             flash_blink;
	logic [W-1:0]     run_half;

	////////////////////////////////////////////////////////////////////////////////
	// byte-lane merge for wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// wishbone decode: one-cycle ack, write on request cycle
	assign wr        = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
	assign start_cmd = wr && i_wb_adr == psio_pkg::OFS_CTRL && i_wb_sel[0]
		&& i_wb_dat[psio_pkg::CTRL_START];
	assign stop_cmd  = wr && i_wb_adr == psio_pkg::OFS_CTRL && i_wb_sel[0]
		&& i_wb_dat[psio_pkg::CTRL_STOP];
	assign clear_cmd = wr && i_wb_adr == psio_pkg::OFS_CTRL && i_wb_sel[0]
		&& i_wb_dat[psio_pkg::CTRL_CLEAR_FAULT];

	// read multiplexer, unmapped reads return zero
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		case (i_wb_adr)
			psio_pkg::OFS_CTRL: begin
				rd_data[psio_pkg::STAT_RUN]     = run;
				rd_data[psio_pkg::STAT_ERR]     = err_active;
				rd_data[psio_pkg::STAT_SERIOUS] = err_serious;
				rd_data[psio_pkg::STAT_MINOR]   = err_minor;
			end
			psio_pkg::OFS_IN_DIS:    rd_data = 32'(in_dis);
			psio_pkg::OFS_IN_FORCE:  rd_data = 32'(in_force);
			psio_pkg::OFS_OUT_DIS:   rd_data = 32'(out_dis);
			psio_pkg::OFS_OUT_FORCE: rd_data = 32'(out_force);
			psio_pkg::OFS_IN_IMAGE:  rd_data = 32'(o_input_image);
			psio_pkg::OFS_OUT_STATE: rd_data = 32'(o_output_point);
			psio_pkg::OFS_ERR_CODE:  rd_data = 32'(err_code);
			psio_pkg::OFS_IRQ_STAT:  rd_data = 32'(irq_stat);
			psio_pkg::OFS_IRQ_MASK:  rd_data = 32'(irq_mask);
			default:                 rd_ok   = 1'b0;
		endcase
	end

	// ack and registered read data
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
			o_wb_dat <= (rd_ok && !i_wb_we) ? rd_data : 32'h0000_0000;
		end
	end

	// disable and force registers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			in_dis    <= '0;
			in_force  <= '0;
			out_dis   <= '0;
			out_force <= '0;
		end else if (wr) begin
			case (i_wb_adr)
				psio_pkg::OFS_IN_DIS:
					in_dis <= N_IN'(merge(32'(in_dis), i_wb_dat, i_wb_sel));
				psio_pkg::OFS_IN_FORCE:
					in_force <= N_IN'(merge(32'(in_force), i_wb_dat, i_wb_sel));
				psio_pkg::OFS_OUT_DIS:
					out_dis <= N_OUT'(merge(32'(out_dis), i_wb_dat, i_wb_sel));
				psio_pkg::OFS_OUT_FORCE:
					out_force <= N_OUT'(merge(32'(out_force), i_wb_dat, i_wb_sel));
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers: three flops, change taken when second and third agree
	for (genvar g = 0; g < N_IN; g++) begin : g_in
		logic s1;
		logic s2;
		logic s3;
		always_ff @(posedge i_clk) begin
			if (i_reset) begin
				s1         <= 1'b0;
				s2         <= 1'b0;
				s3         <= 1'b0;
				in_filt[g] <= 1'b0;
			end else begin
				s1 <= i_input_point[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					in_filt[g] <= s3;
				end
			end
		end
	end

	// input image and input leds
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_input_image <= '0;
			o_input_led   <= '0;
		end else begin
			o_input_image <= (in_dis & in_force) | (~in_dis & in_filt); // R1 R3
			o_input_led   <= in_filt; // R15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output drive: force for disabled points, code display blanks outputs 0-3
	always_comb begin
		next_out = (out_dis & out_force) | (~out_dis & i_scan_out); // R2 R3
		if (anomaly) begin
			next_out[3:0] = 4'h0; // R11
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_output_point <= '0;
			o_output_led   <= '0;
		end else begin
			o_output_point <= next_out;
			o_output_led   <= next_out; // R16
			if (anomaly) begin
				o_output_led[3:0] <= err_code; // R11 R12
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault latch: minor cleared only by reset, serious by clear command
	assign err_active = err_minor || err_serious;
	assign anomaly    = err_active && err_code != psio_pkg::ERR_NONE;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin // R9
			err_minor   <= 1'b0;
			err_serious <= 1'b0;
			err_code    <= psio_pkg::ERR_NONE;
		end else if (i_fault) begin
			err_minor   <= err_minor || !i_fault_serious;
			err_serious <= err_serious || i_fault_serious;
			err_code    <= i_fault_code;
		end else if (clear_cmd && err_serious) begin // R9
			err_serious <= 1'b0;
			if (!err_minor) begin
				err_code <= psio_pkg::ERR_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// run state: restored after reset, changed by tool, stopped by faults
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			run          <= 1'b0;
			booting      <= 1'b1;
			o_retain_run <= 1'b0;
		end else if (booting) begin
			booting      <= 1'b0;
			o_retain_run <= i_retained_run; // R6
			if (i_pack_present) begin
				run <= i_pack_syntax_ok; // R7
			end else begin
				run <= i_retained_run; // R6
			end
			// a fault in the boot cycle must not leave the block running
			if (i_fault) begin
				run <= 1'b0; // R8
			end
		end else if (i_fault) begin
			run <= 1'b0; // R8
		end else if (stop_cmd) begin
			run          <= 1'b0; // R6
			o_retain_run <= 1'b0;
		end else if (start_cmd && !err_active) begin
			run          <= 1'b1; // R6 R9
			o_retain_run <= 1'b1;
		end
	end
	assign o_scan_enable = run;

	////////////////////////////////////////////////////////////////////////////////
	// built-in port: reply granted only after a request has been received
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rx_q        <= 1'b0;
			tx_q        <= 1'b0;
			req_pending <= 1'b0;
			o_rx_led    <= 1'b0;
			o_tx_led    <= 1'b0;
		end else begin
			rx_q     <= i_rx_busy;
			tx_q     <= i_tx_busy;
			o_rx_led <= i_rx_busy; // R14
			o_tx_led <= i_tx_busy; // R14
			if (rx_q && !i_rx_busy) begin
				req_pending <= 1'b1; // R13
			end else if (tx_q && !i_tx_busy) begin
				req_pending <= 1'b0;
			end
		end
	end
	assign o_tx_grant = req_pending; // R13

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins
	assign irq_set[psio_pkg::IRQ_FAULT]   = i_fault;
	assign irq_set[psio_pkg::IRQ_SERIOUS] = i_fault && i_fault_serious;
	assign irq_set[psio_pkg::IRQ_RUNCHG]  = (i_fault && run) || (stop_cmd && run)
		|| (start_cmd && !run && !err_active);
	assign irq_set[psio_pkg::IRQ_REQUEST] = rx_q && !i_rx_busy;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_stat <= '0;
		end else if (wr && i_wb_adr == psio_pkg::OFS_IRQ_STAT && i_wb_sel[0]) begin
			irq_stat <= (irq_stat & ~i_wb_dat[psio_pkg::IRQ_BITS-1:0]) | irq_set;
		end else begin
			irq_stat <= irq_stat | irq_set;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_mask <= psio_pkg::IRQ_MASK_RESET;
		end else if (wr && i_wb_adr == psio_pkg::OFS_IRQ_MASK && i_wb_sel[0]) begin
			irq_mask <= i_wb_dat[psio_pkg::IRQ_BITS-1:0];
		end
	end
	assign o_irq = |(irq_stat & irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	// indicators: run blink rate by state, error steady or flashing
	assign run_half = run ? W'(RUN_HALF) : W'(STOP_HALF); // R4 R5

	psio_blink #(.W(W)) u_run_blink (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_enable (!booting),
		.i_half   (run_half),
		.o_led    (run_blink)
	);

	psio_blink #(.W(W)) u_flash_blink (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_enable (anomaly),
		.i_half   (W'(FLASH_HALF)),
		.o_led    (flash_blink)
	);

	assign o_run_led         = run_blink; // R4 R5
	assign o_err_led         = anomaly ? flash_blink : err_active; // R10 R11
	assign o_power_indicator = !i_reset;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_in_disabled_hold: assert property (@(posedge i_clk) disable iff (i_reset) // R1
		$past(in_dis[0]) && !$past(i_reset) |-> o_input_image[0] == $past(in_force[0]))
		else $error("disabled input image not forced");

	a_out_force_value: assert property (@(posedge i_clk) disable iff (i_reset) // R2
		$past(out_dis[N_OUT-1]) && !$past(i_reset) |->
		o_output_point[N_OUT-1] == $past(out_force[N_OUT-1]))
		else $error("disabled output not at forced value");

	a_out_follow_scan: assert property (@(posedge i_clk) disable iff (i_reset) // R3
		!$past(i_reset) && $past(out_dis) == '0 && !$past(anomaly) |->
		o_output_point == $past(i_scan_out))
		else $error("enabled outputs not following scan");

	a_fault_stops_run: assert property (@(posedge i_clk) disable iff (i_reset) // R8
		i_fault |=> !run && err_active ##1 !run)
		else $error("fault did not stop run");

	a_serious_refuse: assert property (@(posedge i_clk) disable iff (i_reset) // R9
		err_serious && !run && !i_fault && !booting && start_cmd |=> !run)
		else $error("start accepted during serious fault");

	a_err_dark: assert property (@(posedge i_clk) disable iff (i_reset) // R10
		!err_active |-> !o_err_led)
		else $error("error led lit without error");

	a_code_display: assert property (@(posedge i_clk) disable iff (i_reset) // R11
		anomaly && $stable(err_code) && $past(anomaly) |=>
		o_output_point[3:0] == 4'h0 && o_output_led[3:0] == $past(err_code))
		else $error("error code not shown on outputs 0-3");

	a_reply_after_req: assert property (@(posedge i_clk) disable iff (i_reset) // R13
		$rose(o_tx_grant) |-> $past(rx_q) && !$past(i_rx_busy))
		else $error("reply granted without request");

	a_rx_led_tracks: assert property (@(posedge i_clk) disable iff (i_reset) // R14
		!$past(i_reset) |-> o_rx_led == $past(i_rx_busy) && o_tx_led == $past(i_tx_busy))
		else $error("activity led not tracking port");

	a_pack_boot_run: assert property (@(posedge i_clk) disable iff (i_reset) // R7
		booting && i_pack_present && i_pack_syntax_ok && !i_fault |=> run [*2])
		else $error("program pack did not start run");
endmodule : psio_top

// File: sim/psio_host.sv
// partner model: host tool that sends one request and then takes the reply
`timescale 1ns/1ps
module psio_host (
	input  wire logic       i_clk,
	input  wire logic       i_go,
	input  wire logic [7:0] i_len,
	input  wire logic       i_tx_grant,
	output logic            o_rx_busy,
	output logic            o_tx_busy,
	output logic            o_done
);
	////////////////////////////////////////////////////////////////////////////////
	// request first, reply only once the device grants it
	initial begin
		o_rx_busy = 1'b0;
		o_tx_busy = 1'b0;
		o_done    = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_done    <= 1'b0;
				o_rx_busy <= 1'b1;
				repeat (i_len) @(posedge i_clk);
				o_rx_busy <= 1'b0;
				// a slow or prompt reply length both come from i_len
				while (i_tx_grant !== 1'b1) @(posedge i_clk);
				o_tx_busy <= 1'b1;
				repeat (i_len) @(posedge i_clk);
				o_tx_busy <= 1'b0;
				o_done    <= 1'b1;
			end
		end
	end
endmodule : psio_host

// File: sim/psio_top_tb.sv
// testbench: plc supervisor indicators, run state, faults and i/o override
`timescale 1ns/1ps
module psio_top_tb;
	typedef struct packed {
		logic [7:0] in_dis, in_frc, out_dis, out_frc, pin, scan, img, outv;
	} psio_row_s;
	logic        clk, rst, cyc, stb, we, irq, ack, rret, pack, pok, retain, scen;
	logic        flt, fser, rxb, txb, grant, rxl, txl, pwr, runl, errl, go, done;
	logic [7:0]  adr, pin, img, inled, scan, opt, oled, len;
	logic [3:0]  fcode;
	logic [31:0] wdat, rdat, q;
	int          err_count, num_checks;
	psio_row_s   rows [4];
	logic [3:0]  codes [12];
	////////////////////////////////////////////////////////////////////////////////
	// design and host model
	psio_top #(.STOP_HALF(40), .RUN_HALF(5), .FLASH_HALF(10)) psio_top_inst (
		.i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_irq(irq), .i_input_point(pin), .o_input_image(img), .o_input_led(inled),
		.i_scan_out(scan), .o_output_point(opt), .o_output_led(oled), .i_retained_run(rret),
		.i_pack_present(pack), .i_pack_syntax_ok(pok), .o_retain_run(retain),
		.o_scan_enable(scen), .i_fault(flt), .i_fault_serious(fser), .i_fault_code(fcode),
		.i_rx_busy(rxb), .i_tx_busy(txb), .o_tx_grant(grant), .o_rx_led(rxl),
		.o_tx_led(txl), .o_power_indicator(pwr), .o_run_led(runl), .o_err_led(errl));
	psio_host psio_host_inst (.i_clk(clk), .i_go(go), .i_len(len), .i_tx_grant(grant),
		.o_rx_busy(rxb), .o_tx_busy(txb), .o_done(done));
	// clock generation
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	// helper tasks
	task automatic end_of_test;
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		@(posedge clk);
	endtask : wb
	function automatic logic flag_of(input int w);
		return (w != 0) ? done : txb;
	endfunction : flag_of
	task automatic wait_hi(input int w);
		int n;
		n = 0;
		while (flag_of(w) !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) err_count++;
	endtask : wait_hi
	task automatic rst_dut;
		rst <= 1'b1;
		tick(2);
		chk(32'(pwr), 32'h0);
		rst <= 1'b0;
		tick(3);
	endtask : rst_dut
	task automatic pulse_fault(input logic s, input logic [3:0] c);
		flt   <= 1'b1;
		fser  <= s;
		fcode <= c;
		@(posedge clk);
		flt <= 1'b0;
		tick(3);
	endtask : pulse_fault
	function automatic logic led_of(input int w);
		return (w != 0) ? errl : runl;
	endfunction : led_of
	// length of one lit phase of the run or error indicator
	task automatic half_len(input int w, input int exp);
		int n;
		n = 0;
		while (led_of(w) !== 1'b0 && n < 400) begin @(posedge clk); n++; end
		while (led_of(w) !== 1'b1 && n < 800) begin @(posedge clk); n++; end
		n = 0;
		while (led_of(w) === 1'b1 && n < 400) begin @(posedge clk); n++; end
		chk(32'(n), 32'(exp));
	endtask : half_len
	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial begin
		#(50 * 20000);
		err_count++;
		end_of_test();
	end
	// main sequence
	initial begin
		clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; pin = 0; scan = 0;
		rret = 0; pack = 0; pok = 0; flt = 0; fser = 0; fcode = 0; go = 0; len = 2;
		err_count = 0; num_checks = 0;
		rows[0] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h3C, 8'hA5, 8'h3C};
		rows[1] = '{8'hF0, 8'h50, 8'h0F, 8'h09, 8'h0F, 8'hF0, 8'h5F, 8'hF9};
		rows[2] = '{8'hFF, 8'h00, 8'hFF, 8'hAA, 8'hFF, 8'h55, 8'h00, 8'hAA};
		rows[3] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h7E, 8'h81, 8'h7E};
		codes = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk(32'(scen), 32'h0);
		chk(32'(pwr), 32'h1);
		wb(1'b0, psio_pkg::OFS_IRQ_MASK, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'hFC, 32'h0);
		chk(q, 32'h0);
		// ordinary override cases from the table
		foreach (rows[i]) begin
			wb(1'b1, psio_pkg::OFS_IN_DIS, 32'(rows[i].in_dis));
			wb(1'b1, psio_pkg::OFS_IN_FORCE, 32'(rows[i].in_frc));
			wb(1'b1, psio_pkg::OFS_OUT_DIS, 32'(rows[i].out_dis));
			wb(1'b1, psio_pkg::OFS_OUT_FORCE, 32'(rows[i].out_frc));
			pin  <= rows[i].pin;
			scan <= rows[i].scan;
			tick(6);
			chk(32'(img), 32'(rows[i].img));
			chk(32'(inled), 32'(rows[i].pin));
			chk(32'(opt), 32'(rows[i].outv));
			chk(32'(oled), 32'(rows[i].outv));
		end
		half_len(0, 40);
		chk(32'(errl), 32'h0);
		// host request and reply, short and long
		chk(32'(grant), 32'h0);
		for (int k = 0; k < 2; k++) begin
			len <= (k == 0) ? 8'h02 : 8'h09;
			go  <= 1'b1;
			tick(1);
			go <= 1'b0;
			tick(2);
			chk(32'(rxl), 32'h1);
			chk(32'(grant), 32'h0);
			wait_hi(0);
			tick(2);
			chk(32'(txl), 32'h1);
			wait_hi(1);
			tick(2);
			chk(32'({rxl, txl, grant}), 32'h0);
		end
		// run command, interrupt raise, clear and mask
		wb(1'b0, psio_pkg::OFS_IRQ_STAT, 32'h0);
		chk(q, 32'h8);
		wb(1'b1, psio_pkg::OFS_IRQ_STAT, 32'hF);
		wb(1'b1, psio_pkg::OFS_IRQ_MASK, 32'h4);
		chk(32'(irq), 32'h0);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h1);
		tick(1);
		chk(32'({scen, retain, irq}), 32'h7);
		half_len(0, 5);
		chk(32'(errl), 32'h0);
		wb(1'b1, psio_pkg::OFS_IRQ_STAT, 32'h4);
		chk(32'(irq), 32'h0);
		wb(1'b1, psio_pkg::OFS_IRQ_MASK, 32'h0);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h3);
		tick(1);
		chk(32'({scen, irq}), 32'h0);
		wb(1'b0, psio_pkg::OFS_IRQ_STAT, 32'h0);
		chk(q, 32'h4);
		// every error code after a retained run
		rret <= 1'b1;
		scan <= 8'hFF;
		foreach (codes[i]) begin
			rst_dut();
			chk(32'(scen), 32'h1);
			pulse_fault(1'b0, codes[i]);
			chk(32'({scen, errl}), 32'h1);
			chk(32'(oled), 32'({4'hF, codes[i]}));
			chk(32'(opt), 32'hF0);
		end
		half_len(1, 10);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h1);
		tick(1);
		chk(32'(scen), 32'h0);
		rst_dut();
		chk(32'({scen, errl}), 32'h2);
		// serious fault blocks start until cleared
		pulse_fault(1'b1, 4'h4);
		wb(1'b0, psio_pkg::OFS_IRQ_STAT, 32'h0);
		chk(q, 32'h7);
		wb(1'b0, psio_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h6);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h1);
		tick(1);
		chk(32'(scen), 32'h0);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h4);
		wb(1'b1, psio_pkg::OFS_CTRL, 32'h1);
		tick(1);
		chk(32'(scen), 32'h1);
		// program pack at power-up
		rret <= 1'b0;
		pack <= 1'b1;
		pok  <= 1'b1;
		rst_dut();
		chk(32'(scen), 32'h1);
		pok <= 1'b0;
		rst_dut();
		chk(32'(scen), 32'h0);
		end_of_test();
	end
endmodule : psio_top_tb
